// ### verilog/rdim_defs.vh
// Register offsets, field positions and reset values for the interrupt mask logic.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef RDIM_DEFS_VH
`define RDIM_DEFS_VH
// =====================================================================
// Register offsets
`define RDIM_ADDR_W          16
`define RDIM_OFS_REF_LOW     16'h0080
`define RDIM_OFS_REF_HIGH    16'h0081
`define RDIM_OFS_LOOP        16'h0082
`define RDIM_OFS_REF_MON0    16'h0084
`define RDIM_OFS_LOOP_MON0   16'h0094
`define RDIM_OFS_REF_ACTIVE  16'h0182
`define RDIM_OFS_REF_ACTHI   16'h0183
`define RDIM_OFS_LOOP_ACTIVE 16'h0184
// =====================================================================
// Field layout and reset values
`define RDIM_NUM_REF         10
`define RDIM_NUM_LOOP        4
`define RDIM_MON_W           5
`define RDIM_REF_HIGH_MASK   8'h03
`define RDIM_LOOP_MASK       8'h0F
`define RDIM_MON_MASK        8'h1F
`define RDIM_RST_VAL         8'h00
`endif

// ### verilog/rdim_irq_mask.v
// Interrupt mask logic: reference and loop masks, monitor masks, failure flags, interrupt pin.
// Assumes monitor status inputs come from logic on the same clock and a simple
// synchronous 8-bit register port driven by the host interface logic.
// Function
// - Eight-bit mask register, bit N gates interrupts for reference N, 0..7.
// - Reference masks only matter while the interrupt output function is enabled.
// - Mask bit zero: reference change neither raises interrupt nor sets its flag.
// - Mask bit one: qualifying reference changes raise interrupt and set flag.
// - Per-reference monitor mask selects which status changes qualify.
// - Second mask register holds references 8 and 9; bits 7:2 reserved.
// - Loop mask bits 3:0 for loops 0..3, 7:4 reserved, used only when enabled.
// - Loop mask bit zero: loop change neither raises interrupt nor sets flag.
// - Loop mask bit one: qualifying loop changes raise interrupt and set flag.
// - Per-loop monitor mask selects which loop status changes qualify.
// - Reference monitor mask bits: los, scm, cfm, gst, pfm; one unmasks.
`timescale 1ns/10ps
`include "rdim_defs.vh"

module rdim_irq_mask #(
  parameter NREF  = `RDIM_NUM_REF,
  parameter NLOOP = `RDIM_NUM_LOOP,
  parameter MONW  = `RDIM_MON_W
) (
  input  wire                      clock,
  input  wire                      rst,
  input  wire                      irqEnable,
  input  wire [NREF*MONW-1:0]      refStatus,
  input  wire [NLOOP*MONW-1:0]     loopStatus,
  input  wire                      regWrite,
  input  wire                      regRead,
  input  wire [`RDIM_ADDR_W-1:0]   regAddr,
  input  wire [7:0]                regWdata,
  output reg  [7:0]                regRdata,
  output reg                       irqPin,
  output reg  [NREF-1:0]           refFail,
  output reg  [NLOOP-1:0]          loopFail
);

  // =====================================================================
  // Register storage and change history
  reg [7:0]            refMaskLow_r;
  reg [7:0]            refMaskHigh_r;
  reg [7:0]            loopMask_r;
  reg [7:0]            refMon_r  [0:NREF-1];
  reg [7:0]            loopMon_r [0:NLOOP-1];
  reg [NREF*MONW-1:0]  refPrev_r;
  reg [NLOOP*MONW-1:0] loopPrev_r;
  reg [7:0]            rdMux;
  integer              kw;
  integer              kr;

  // =====================================================================
  // Address decode
  // Each register address is compared in one place; the write path, the
  // flag clears and the read mux all work from these selects.
  wire                 selRefLow;
  wire                 selRefHigh;
  wire                 selLoop;
  wire                 selRefAct;
  wire                 selRefActHi;
  wire                 selLoopAct;
  wire [NREF-1:0]      selRefMon;
  wire [NLOOP-1:0]     selLoopMon;

  assign selRefLow   = (regAddr == `RDIM_OFS_REF_LOW);
  assign selRefHigh  = (regAddr == `RDIM_OFS_REF_HIGH);
  assign selLoop     = (regAddr == `RDIM_OFS_LOOP);
  assign selRefAct   = (regAddr == `RDIM_OFS_REF_ACTIVE);
  assign selRefActHi = (regAddr == `RDIM_OFS_REF_ACTHI);
  assign selLoopAct  = (regAddr == `RDIM_OFS_LOOP_ACTIVE);

  // =====================================================================
  // Event and flag wiring
  wire [15:0]          refMaskAll;
  wire [15:0]          refClrAll;
  wire [7:0]           loopClrAll;
  wire [15:0]          refFailAll;
  wire [7:0]           loopFailAll;
  wire [NREF-1:0]      refEvent;
  wire [NLOOP-1:0]     loopEvent;
  wire [NREF-1:0]      refFail_nxt;
  wire [NLOOP-1:0]     loopFail_nxt;

  assign refMaskAll  = {refMaskHigh_r, refMaskLow_r};
  // Flags clear by writing one to their bit; a write that does not address
  // a flag register contributes no ones.
  assign refClrAll   = {((regWrite && selRefActHi) ? regWdata : 8'h00),
                        ((regWrite && selRefAct) ? regWdata : 8'h00)};
  assign loopClrAll  = (regWrite && selLoopAct) ? regWdata : 8'h00;
  assign refFailAll  = {{(16-NREF){1'b0}}, refFail};
  assign loopFailAll = {{(8-NLOOP){1'b0}}, loopFail};

  // =====================================================================
  // Mask registers
  always @(posedge clock) begin
    if (rst) begin
      refMaskLow_r  <= `RDIM_RST_VAL;
      refMaskHigh_r <= `RDIM_RST_VAL;
      loopMask_r    <= `RDIM_RST_VAL;
    end else if (regWrite) begin
      if (selRefLow) begin
        refMaskLow_r <= regWdata;
      end else if (selRefHigh) begin
        refMaskHigh_r <= regWdata & `RDIM_REF_HIGH_MASK;
      end else if (selLoop) begin
        loopMask_r <= regWdata & `RDIM_LOOP_MASK;
      end
    end
  end

  // Monitor masks keep only the five source enables; the reserved upper
  // bits are dropped on write so that they always read back as zero.
  always @(posedge clock) begin
    if (rst) begin
      for (kw = 0; kw < NREF; kw = kw + 1) begin
        refMon_r[kw] <= `RDIM_RST_VAL;
      end
      for (kw = 0; kw < NLOOP; kw = kw + 1) begin
        loopMon_r[kw] <= `RDIM_RST_VAL;
      end
    end else if (regWrite) begin
      for (kw = 0; kw < NREF; kw = kw + 1) begin
        if (selRefMon[kw]) begin
          refMon_r[kw] <= regWdata & `RDIM_MON_MASK;
        end
      end
      for (kw = 0; kw < NLOOP; kw = kw + 1) begin
        if (selLoopMon[kw]) begin
          loopMon_r[kw] <= regWdata & `RDIM_MON_MASK;
        end
      end
    end
  end

  // The previous-cycle copies follow the status inputs through reset as well,
  // so a source that is already active when reset ends is not seen as a change.
  always @(posedge clock) begin
    refPrev_r  <= refStatus;
    loopPrev_r <= loopStatus;
  end

  // =====================================================================
  // Per-reference change detection and failure flags
  // A change is any edge of a status source; both directions count so that
  // recovery is reported as well as failure.
  genvar gi;
  generate
    for (gi = 0; gi < NREF; gi = gi + 1) begin : gRef
      localparam [31:0] MON_ADR = `RDIM_OFS_REF_MON0 + gi;
      wire [MONW-1:0] chg = refStatus[gi*MONW +: MONW] ^ refPrev_r[gi*MONW +: MONW];
      assign selRefMon[gi] = (regAddr == MON_ADR[`RDIM_ADDR_W-1:0]);
      assign refEvent[gi] = irqEnable && refMaskAll[gi] && |(chg & refMon_r[gi][MONW-1:0]);
      // A new event wins over a clear written in the same cycle.
      assign refFail_nxt[gi] = refEvent[gi] ? 1'b1 :
        (refClrAll[gi] ? 1'b0 : refFail[gi]);
    end

    // Per-loop change detection and failure flags
    for (gi = 0; gi < NLOOP; gi = gi + 1) begin : gLoop
      localparam [31:0] MON_ADR = `RDIM_OFS_LOOP_MON0 + gi;
      wire [MONW-1:0] chg = loopStatus[gi*MONW +: MONW] ^ loopPrev_r[gi*MONW +: MONW];
      assign selLoopMon[gi] = (regAddr == MON_ADR[`RDIM_ADDR_W-1:0]);
      assign loopEvent[gi] = irqEnable && loopMask_r[gi] && |(chg & loopMon_r[gi][MONW-1:0]);
      // A new event wins over a clear written in the same cycle.
      assign loopFail_nxt[gi] = loopEvent[gi] ? 1'b1 :
        (loopClrAll[gi] ? 1'b0 : loopFail[gi]);
    end
  endgenerate

  // =====================================================================
  // Failure flags and interrupt pin
  // The pin is registered from the next flag values so that it changes on
  // the same edge as the flags and never lags them by a cycle.
  always @(posedge clock) begin
    if (rst) begin
      refFail  <= {NREF{1'b0}};
      loopFail <= {NLOOP{1'b0}};
      irqPin   <= 1'b0;
    end else begin
      refFail  <= refFail_nxt;
      loopFail <= loopFail_nxt;
      irqPin   <= (|refFail_nxt) | (|loopFail_nxt);
    end
  end

  // =====================================================================
  // Read port
  // Data is registered on the read strobe and holds until the next read;
  // unmapped addresses read zero.
  always @* begin
    rdMux = 8'h00;
    if (selRefLow) begin
      rdMux = refMaskLow_r;
    end else if (selRefHigh) begin
      rdMux = refMaskHigh_r;
    end else if (selLoop) begin
      rdMux = loopMask_r;
    end else if (selRefAct) begin
      rdMux = refFailAll[7:0];
    end else if (selRefActHi) begin
      rdMux = refFailAll[15:8];
    end else if (selLoopAct) begin
      rdMux = loopFailAll;
    end else begin
      for (kr = 0; kr < NREF; kr = kr + 1) begin
        if (selRefMon[kr]) begin
          rdMux = refMon_r[kr];
        end
      end
      for (kr = 0; kr < NLOOP; kr = kr + 1) begin
        if (selLoopMon[kr]) begin
          rdMux = loopMon_r[kr];
        end
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      regRdata <= `RDIM_RST_VAL;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

endmodule

// ### verification/rdim_status_src.sv
// Model of the reference and loop monitors feeding status levels.
// Assumes the bench calls flip; levels move just after a clock edge.
`timescale 1ns/10ps
module rdim_status_src (
  input  wire        clock,
  output reg  [49:0] refStatus,
  output reg  [19:0] loopStatus
);
  initial refStatus = 50'h0;
  initial loopStatus = 20'h0;
  // Bit b of unit n sits at n*5+b: los, scm, cfm, gst, pfm upwards.
  task flip(input loopSel, input integer pos);
    begin
      @(posedge clock);
      if (loopSel)
        loopStatus[pos] <= ~loopStatus[pos];
      else
        refStatus[pos] <= ~refStatus[pos];
    end
  endtask
endmodule

// ### verification/rdim_irq_mask_monitor.sv
// Checker on the mask block ports.
// Assumes one clock and a bind from the testbench.
`timescale 1ns/10ps
module rdim_irq_mask_monitor #(parameter NREF = 10, parameter NLOOP = 4, parameter MONW = 5) (
  input wire                   clock,
  input wire                   rst,
  input wire                   irqEnable,
  input wire [NREF*MONW-1:0]   refStatus,
  input wire [NLOOP*MONW-1:0]  loopStatus,
  input wire                   regWrite,
  input wire                   regRead,
  input wire [15:0]            regAddr,
  input wire [7:0]             regWdata,
  input wire [7:0]             regRdata,
  input wire                   irqPin,
  input wire [NREF-1:0]        refFail,
  input wire [NLOOP-1:0]       loopFail
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // Relations
  a_pin_follows: assert property (irqPin == (|refFail || |loopFail)) else $error("pin vs flags");
  a_off_noset: assert property (!irqEnable |=> ((refFail & ~$past(refFail)) == 0)
    && ((loopFail & ~$past(loopFail)) == 0)) else $error("set while off");
  a_ref_quiet: assert property ($stable(refStatus) |=> (refFail & ~$past(refFail)) == 0) else $error("ref set");
  a_loop_quiet: assert property ($stable(loopStatus) |=> (loopFail & ~$past(loopFail)) == 0) else $error("loop set");
  a_loop_clear: assert property (regWrite && regAddr == 16'h0184 && regWdata == 8'h0F && $stable(loopStatus)
    |=> loopFail == 0) else $error("loop not cleared");
  a_high_resv: assert property (regRead && regAddr == 16'h0081 |=> regRdata[7:2] == 0) else $error("high resv");
  a_loop_resv: assert property (regRead && regAddr == 16'h0082 |=> regRdata[7:4] == 0) else $error("loop resv");
  a_rdata_hold: assert property (!regRead |=> $stable(regRdata)) else $error("rdata moved");
  a_mon_resv: assert property (regRead && regAddr == 16'h0084 |=> regRdata[7:5] == 0) else $error("mon resv");
  a_ref_clear: assert property (regWrite && regAddr == 16'h0182 && $stable(refStatus)
    |=> (refFail[7:0] & $past(regWdata)) == 0) else $error("ref not cleared");
  c_raise: cover property ($rose(irqPin));
  c_drop: cover property ($fell(irqPin));
  c_clear: cover property (regWrite && regAddr == 16'h0182);
endmodule

// ### verification/testbench.sv
// Bench for the interrupt mask block: register tasks and a status source.
// Assumes design, checker and source model are compiled first.
`timescale 1ns/10ps
module testbench;
  reg         clock = 1'b0, rst = 1'b1, irqEnable = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  reg  [15:0] regAddr = 16'h0000;
  reg  [7:0]  regWdata = 8'h00;
  wire [7:0]  regRdata;
  wire [9:0]  refFail;
  wire [3:0]  loopFail;
  wire [49:0] refStatus;
  wire [19:0] loopStatus;
  wire        irqPin;
  integer     mismatches = 0, comparisons = 0;
  rdim_status_src i_src (
    .clock      (clock),
    .refStatus  (refStatus),
    .loopStatus (loopStatus)
  );
  rdim_irq_mask i_dut (
    .clock      (clock),
    .rst        (rst),
    .irqEnable  (irqEnable),
    .refStatus  (refStatus),
    .loopStatus (loopStatus),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .regAddr    (regAddr),
    .regWdata   (regWdata),
    .regRdata   (regRdata),
    .irqPin     (irqPin),
    .refFail    (refFail),
    .loopFail   (loopFail)
  );
  initial forever #2.5 clock = ~clock;
  task chk(input [14:0] got, input [14:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A write when rd is 0; a read compared against d when rd is 1.
  task acc(input rd, input [15:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regRead <= rd;
      regWrite <= ~rd;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regRead <= 1'b0;
      regWrite <= 1'b0;
      @(posedge clock);
      #1 if (rd) chk({7'h00, regRdata}, {7'h00, d});
    end
  endtask
  task ev(input lp, input integer pos, input [14:0] exp);
    begin
      i_src.flip(lp, pos);
      repeat (2) @(posedge clock);
      #1 chk({irqPin, loopFail, refFail}, exp);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    acc(1, 16'h0080, 8'h00);
    acc(1, 16'h0081, 8'h00);
    acc(1, 16'h0082, 8'h00);
    acc(0, 16'h0080, 8'hFF);
    acc(0, 16'h0081, 8'hFF);
    acc(0, 16'h0082, 8'hFF);
    acc(1, 16'h0080, 8'hFF);
    acc(1, 16'h0081, 8'h03);
    acc(1, 16'h0082, 8'h0F);
    acc(1, 16'h0083, 8'h00);
    acc(0, 16'h0084, 8'hFF);
    acc(1, 16'h0084, 8'h1F);
    $display("test done: registers");
    acc(0, 16'h0084, 8'h01);
    acc(0, 16'h008D, 8'h10);
    acc(0, 16'h0094, 8'h1F);
    acc(1, 16'h0094, 8'h1F);
    ev(0, 0, 15'h0000);
    @(posedge clock);
    irqEnable <= 1'b1;
    ev(0, 0, 15'h4001);
    ev(0, 1, 15'h4001);
    ev(0, 49, 15'h4201);
    ev(1, 0, 15'h4601);
    ev(1, 5, 15'h4601);
    acc(1, 16'h0182, 8'h01);
    acc(1, 16'h0183, 8'h02);
    acc(1, 16'h0184, 8'h01);
    acc(0, 16'h0182, 8'h01);
    acc(0, 16'h0183, 8'h02);
    chk({irqPin, loopFail, refFail}, 15'h4400);
    acc(0, 16'h0184, 8'h0F);
    chk({irqPin, loopFail, refFail}, 15'h0000);
    acc(0, 16'h0080, 8'h00);
    acc(0, 16'h0082, 8'h00);
    ev(0, 0, 15'h0000);
    ev(1, 0, 15'h0000);
    $display("test done: masking");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    acc(1, 16'h0081, 8'h00);
    acc(1, 16'h0084, 8'h00);
    $display("test done: reset");
    conclude;
  end
endmodule
bind rdim_irq_mask rdim_irq_mask_monitor #(.NREF(NREF), .NLOOP(NLOOP), .MONW(MONW)) i_mon (
  .clock      (clock),
  .rst        (rst),
  .irqEnable  (irqEnable),
  .refStatus  (refStatus),
  .loopStatus (loopStatus),
  .regWrite   (regWrite),
  .regRead    (regRead),
  .regAddr    (regAddr),
  .regWdata   (regWdata),
  .regRdata   (regRdata),
  .irqPin     (irqPin),
  .refFail    (refFail),
  .loopFail   (loopFail)
);
